// File: logic/htf_framer.v
// Host telegram framer: parses command telegrams from a byte stream,
// hands good ones to the device core and sends framed responses.
// Assumes a UART byte stream on ref_clk and a core on the same clock.
`timescale 1ns/1ps
`default_nettype none
`include "htf_map.vh"

// Operation
// R1: STX opens, ETX closes each telegram
// R2: Individual station address at most 125
// R3: Address 126 is broadcast, accepted by all
// R4: Byte count covers code, reserve, condition, data
// R5: Payload never longer than 128 bytes
// R6: Code, reserve, condition follow the count
// R7: Ones complement 16-bit sum, address to data
// R8: Response sets bit 7 of command code
// R9: Response uses same layout and checksum
// R10: Bad checksum answered with FF/FF error ack
// R11: Unknown command gets distinct error code
// R12: Checksum high byte first, low byte second
// R13: Missing end byte discards frame, rehunt
module htf_framer #(
  parameter FIFO_DEPTH = 8,
  parameter FIFO_AW    = 3
) (
  input  wire       ref_clk,
  input  wire       srst,
  input  wire [6:0] station_addr,
  input  wire [7:0] rx_data,
  input  wire       rx_valid,
  output wire [7:0] tx_data,
  output wire       tx_valid,
  input  wire       tx_ready,
  output reg        cmd_valid_r,
  output reg  [7:0] cmd_code_r,
  output reg  [7:0] cmd_reserve_r,
  output reg  [7:0] cmd_cond_r,
  output reg  [7:0] cmd_count_r,
  output reg        cmd_bcast_r,
  input  wire [6:0] pay_raddr,
  output wire [7:0] pay_rdata,
  input  wire       pay_we,
  input  wire [6:0] pay_waddr,
  input  wire [7:0] pay_wdata,
  input  wire       rsp_req,
  input  wire [7:0] rsp_code,
  input  wire [7:0] rsp_cond,
  input  wire [7:0] rsp_count,
  input  wire       rsp_unknown,
  output reg        busy_r
);

  localparam [3:0] ST_HUNT = 4'h0;
  localparam [3:0] ST_ADDR = 4'h1;
  localparam [3:0] ST_CNT  = 4'h2;
  localparam [3:0] ST_CODE = 4'h3;
  localparam [3:0] ST_RSV  = 4'h4;
  localparam [3:0] ST_COND = 4'h5;
  localparam [3:0] ST_DATA = 4'h6;
  localparam [3:0] ST_CK1  = 4'h7;
  localparam [3:0] ST_CK2  = 4'h8;
  localparam [3:0] ST_END  = 4'h9;
  localparam [3:0] ST_HOLD = 4'ha;
  localparam [3:0] ST_TXB  = 4'hb;
  localparam [3:0] ST_TXRD = 4'hc;

  reg [3:0]  state_r;
  reg [7:0]  idx_r;
  reg [7:0]  pay_len_r;
  reg [15:0] sum_r;
  reg [15:0] ck_r;
  reg        addr_ok_r;
  reg        bcast_r;
  reg [7:0]  tx_code_r;
  reg [7:0]  tx_rsv_r;
  reg [7:0]  tx_cond_r;
  reg [7:0]  tx_n_r;
  reg        tx_err_r;
  reg [15:0] tx_errc_r;

  reg  [7:0] tx_byte;
  wire       fifo_in_ready;
  wire       push;
  wire [7:0] tx_off;
  wire [7:0] nxt_idx;
  wire [7:0] last_idx;
  wire       rx_take;
  wire [15:0] ck_out;

  assign rx_take  = rx_valid;
  assign push     = (state_r == ST_TXB) & fifo_in_ready;
  assign tx_off   = idx_r - `HTF_TX_DATA0;
  assign nxt_idx  = idx_r + 8'h01;
  assign last_idx = tx_n_r + 8'h08;
  // R7: ones complement of the running sum
  assign ck_out   = ~sum_r;

  // Outgoing byte for the current position in the telegram
  always @*
  begin
    tx_byte = pay_rdata;
    if (idx_r == 8'h00)
      tx_byte = `HTF_STX;
    else if (idx_r == 8'h01)
      tx_byte = {1'b0, station_addr};
    // R4: count excludes address, checksum and delimiters
    else if (idx_r == 8'h02)
      tx_byte = tx_n_r + `HTF_HDR_BYTES;
    else if (idx_r == 8'h03)
      tx_byte = tx_code_r;
    else if (idx_r == 8'h04)
      tx_byte = tx_rsv_r;
    else if (idx_r == 8'h05)
      tx_byte = tx_cond_r;
    // R12: high checksum byte goes first
    else if (idx_r == tx_n_r + 8'h06)
      tx_byte = ck_out[15:8];
    else if (idx_r == tx_n_r + 8'h07)
      tx_byte = ck_out[7:0];
    else if (idx_r == last_idx)
      tx_byte = `HTF_ETX;
    else if (tx_err_r)
      tx_byte = (idx_r == 8'h06) ? tx_errc_r[15:8] : tx_errc_r[7:0];
  end

  // Main sequencer: receive, hold for the core, transmit
  always @(posedge ref_clk)
  begin
    if (srst)
    begin
      state_r       <= ST_HUNT;
      idx_r         <= 8'h00;
      pay_len_r     <= 8'h00;
      sum_r         <= 16'h0000;
      ck_r          <= 16'h0000;
      addr_ok_r     <= 1'b0;
      bcast_r       <= 1'b0;
      tx_code_r     <= 8'h00;
      tx_rsv_r      <= 8'h00;
      tx_cond_r     <= 8'h00;
      tx_n_r        <= 8'h00;
      tx_err_r      <= 1'b0;
      tx_errc_r     <= 16'h0000;
      cmd_valid_r   <= 1'b0;
      cmd_code_r    <= 8'h00;
      cmd_reserve_r <= 8'h00;
      cmd_cond_r    <= 8'h00;
      cmd_count_r   <= 8'h00;
      cmd_bcast_r   <= 1'b0;
      busy_r        <= 1'b0;
    end
    else
    begin
      cmd_valid_r <= 1'b0;
      busy_r      <= (state_r == ST_HOLD) | (state_r == ST_TXB) |
                     (state_r == ST_TXRD);
      case (state_r)
        ST_HUNT:
        begin
          // R1: only a start byte opens a frame
          if (rx_take && rx_data == `HTF_STX)
          begin
            state_r <= ST_ADDR;
            sum_r   <= 16'h0000;
          end
        end
        ST_ADDR:
        begin
          if (rx_take)
          begin
            sum_r   <= sum_r + {8'h00, rx_data};
            // R2: station addresses above 125 are not individual
            addr_ok_r <= (rx_data == {1'b0, station_addr}) &&
                         (rx_data <= `HTF_ADDR_MAX);
            // R3: broadcast reaches every station
            bcast_r <= (rx_data == `HTF_ADDR_BCAST);
            if (rx_data == `HTF_ADDR_BCAST)
              addr_ok_r <= 1'b1;
            // Foreign frames up to address 126 are still parsed so their payload cannot
            // be mistaken for a start byte; higher addresses return to hunting
            state_r <= (rx_data > `HTF_ADDR_BCAST) ? ST_HUNT : ST_CNT;
          end
        end
        ST_CNT:
        begin
          if (rx_take)
          begin
            sum_r <= sum_r + {8'h00, rx_data};
            // R4: count spans the three fixed fields plus data
            // R5: more than 128 payload bytes is refused
            if (rx_data < `HTF_HDR_BYTES || rx_data > `HTF_CNT_MAX)
              state_r <= ST_HUNT;
            else
            begin
              pay_len_r <= rx_data - `HTF_HDR_BYTES;
              state_r   <= ST_CODE;
            end
          end
        end
        // R6: code, reserve and condition in fixed order
        ST_CODE:
        begin
          if (rx_take)
          begin
            sum_r      <= sum_r + {8'h00, rx_data};
            cmd_code_r <= rx_data;
            state_r    <= ST_RSV;
          end
        end
        ST_RSV:
        begin
          if (rx_take)
          begin
            sum_r         <= sum_r + {8'h00, rx_data};
            cmd_reserve_r <= rx_data;
            state_r       <= ST_COND;
          end
        end
        ST_COND:
        begin
          if (rx_take)
          begin
            sum_r      <= sum_r + {8'h00, rx_data};
            cmd_cond_r <= rx_data;
            idx_r      <= 8'h00;
            state_r    <= (pay_len_r == 8'h00) ? ST_CK1 : ST_DATA;
          end
        end
        ST_DATA:
        begin
          if (rx_take)
          begin
            sum_r <= sum_r + {8'h00, rx_data};
            idx_r <= nxt_idx;
            if (nxt_idx == pay_len_r)
              state_r <= ST_CK1;
          end
        end
        // R12: first checksum byte is the high half
        ST_CK1:
        begin
          if (rx_take)
          begin
            ck_r[15:8] <= rx_data;
            state_r    <= ST_CK2;
          end
        end
        ST_CK2:
        begin
          if (rx_take)
          begin
            ck_r[7:0] <= rx_data;
            state_r   <= ST_END;
          end
        end
        ST_END:
        begin
          if (rx_take)
          begin
            // R13: wrong end byte drops the frame
            if (rx_data != `HTF_ETX || !addr_ok_r)
              state_r <= ST_HUNT;
            // R7: verify received sum against the check
            else if (ck_r == ck_out)
            begin
              cmd_valid_r <= 1'b1;
              cmd_count_r <= pay_len_r;
              cmd_bcast_r <= bcast_r;
              state_r     <= ST_HOLD;
            end
            else if (bcast_r)
              state_r <= ST_HUNT;
            else
            begin
              // R10: checksum error acknowledgement
              tx_err_r  <= 1'b1;
              tx_errc_r <= `HTF_ERRC_CKSUM;
              tx_code_r <= `HTF_ERR_CODE;
              tx_rsv_r  <= `HTF_ERR_RSV;
              tx_cond_r <= 8'h00;
              tx_n_r    <= `HTF_ERR_PAY;
              idx_r     <= 8'h00;
              sum_r     <= 16'h0000;
              state_r   <= ST_TXB;
            end
          end
        end
        ST_HOLD:
        begin
          if (rsp_req)
          begin
            idx_r     <= 8'h00;
            sum_r     <= 16'h0000;
            tx_cond_r <= rsp_cond;
            tx_err_r  <= rsp_unknown;
            tx_errc_r <= `HTF_ERRC_UNKNOWN;
            // Broadcast frames are never answered, to avoid collisions
            state_r   <= bcast_r ? ST_HUNT : ST_TXB;
            if (rsp_unknown)
            begin
              // R11: unknown command gets its own error code
              tx_code_r <= `HTF_ERR_CODE;
              tx_rsv_r  <= `HTF_ERR_RSV;
              tx_n_r    <= `HTF_ERR_PAY;
            end
            else
            begin
              // R8: response marker in bit 7
              tx_code_r <= rsp_code | `HTF_RSP_MARK;
              tx_rsv_r  <= `HTF_RSV_NORMAL;
              // R5: response payload clipped at 128 bytes
              tx_n_r    <= (rsp_count > 8'h80) ? 8'h80 : rsp_count;
            end
          end
        end
        // R9: response built with the command's layout
        ST_TXB:
        begin
          if (push)
          begin
            if (idx_r != 8'h00 && idx_r < tx_n_r + 8'h06)
              sum_r <= sum_r + {8'h00, tx_byte};
            idx_r <= nxt_idx;
            if (idx_r == last_idx)
            begin
              tx_err_r <= 1'b0;
              state_r  <= ST_HUNT;
            end
            else if (!tx_err_r && nxt_idx >= `HTF_TX_DATA0 &&
                     nxt_idx < tx_n_r + 8'h06)
              state_r <= ST_TXRD;
          end
        end
        ST_TXRD:
          // Buffer read takes one edge before the byte is ready
          state_r <= ST_TXB;
        default:
          state_r <= ST_HUNT;
      endcase
    end
  end

  // Buffer ports: receiver fills it, core owns it while holding
  wire       mem_we;
  wire [6:0] mem_waddr;
  wire [7:0] mem_wdata;
  wire [6:0] mem_raddr;

  assign mem_we    = ((state_r == ST_DATA) & rx_take) |
                     ((state_r == ST_HOLD) & pay_we);
  assign mem_waddr = (state_r == ST_HOLD) ? pay_waddr : idx_r[6:0];
  assign mem_wdata = (state_r == ST_HOLD) ? pay_wdata : rx_data;
  // Transmit keeps the read port while stalled, or the byte is lost
  assign mem_raddr = ((state_r == ST_TXRD) | (state_r == ST_TXB)) ?
                     tx_off[6:0] : pay_raddr;

  htf_mem #(
    .DW (8),
    .AW (7)
  ) u_mem (
    .ref_clk (ref_clk),
    .srst    (srst),
    .we      (mem_we),
    .waddr   (mem_waddr),
    .wdata   (mem_wdata),
    .raddr   (mem_raddr),
    .rdata_r (pay_rdata)
  );

  // Transmit FIFO; a stalled UART holds the sequencer in ST_TXB
  htf_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH),
    .AW    (FIFO_AW)
  ) u_fifo (
    .ref_clk   (ref_clk),
    .srst      (srst),
    .in_valid  (push),
    .in_ready  (fifo_in_ready),
    .in_data   (tx_byte),
    .out_valid (tx_valid),
    .out_ready (tx_ready),
    .out_data  (tx_data)
  );

endmodule // htf_framer

`default_nettype wire

// File: logic/htf_map.vh
// Constants of the host telegram framer: delimiters, field limits,
// response marker, error acknowledgement layout and error codes.
// Included by the framer; holds definitions only.
`ifndef HTF_MAP_VH
`define HTF_MAP_VH

`define HTF_STX          8'h02
`define HTF_ETX          8'h03
`define HTF_ADDR_MAX     8'h7d
`define HTF_ADDR_BCAST   8'h7e
`define HTF_HDR_BYTES    8'h03
`define HTF_CNT_MAX      8'h83
`define HTF_RSP_MARK     8'h80
`define HTF_RSV_NORMAL   8'h00
`define HTF_ERR_CODE     8'hff
`define HTF_ERR_RSV      8'hff
`define HTF_ERR_PAY      8'h02
`define HTF_ERRC_CKSUM   16'h0001
`define HTF_ERRC_UNKNOWN 16'h0002
`define HTF_TX_DATA0     8'h06

`endif

// File: logic/htf_fifo.v
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none

module htf_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  input  wire             ref_clk,
  input  wire             srst,
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);

  reg [WIDTH-1:0] mem_r [0:DEPTH-1];
  reg [AW-1:0]    wptr_r;
  reg [AW-1:0]    rptr_r;
  reg [AW:0]      count_r;
  reg [AW:0]      count_nxt;
  reg             valid_r;

  wire push;
  wire pop;

  // Full comes from the fill count; valid is its registered twin, so
  // the far side sees a flip-flop and never a decode glitch
  assign in_ready  = (count_r != DEPTH[AW:0]);
  assign out_valid = valid_r;
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  assign out_data  = mem_r[rptr_r];

  // Next fill level, shared by the count and the valid flag
  always @*
  begin
    count_nxt = count_r;
    if (push && !pop)
      count_nxt = count_r + 1'b1;
    else if (pop && !push)
      count_nxt = count_r - 1'b1;
  end

  // Storage array, no reset needed
  always @(posedge ref_clk)
  begin
    if (push)
      mem_r[wptr_r] <= in_data;
  end

  // Pointers and count
  always @(posedge ref_clk)
  begin
    if (srst)
    begin
      wptr_r  <= {AW{1'b0}};
      rptr_r  <= {AW{1'b0}};
      count_r <= {(AW+1){1'b0}};
      valid_r <= 1'b0;
    end
    else
    begin
      if (push)
        wptr_r <= (wptr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}}
                                                    : wptr_r + 1'b1;
      if (pop)
        rptr_r <= (rptr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}}
                                                    : rptr_r + 1'b1;
      count_r <= count_nxt;
      valid_r <= (count_nxt != {(AW+1){1'b0}});
    end
  end

endmodule // htf_fifo

`default_nettype wire

// File: logic/htf_mem.v
// Payload buffer: one write port, one read port with registered data.
// Assumes one clock; read data appear one edge after the address.
`timescale 1ns/1ps
`default_nettype none

module htf_mem #(
  parameter DW = 8,
  parameter AW = 7
) (
  input  wire          ref_clk,
  input  wire          srst,
  input  wire          we,
  input  wire [AW-1:0] waddr,
  input  wire [DW-1:0] wdata,
  input  wire [AW-1:0] raddr,
  output reg  [DW-1:0] rdata_r
);

  reg [DW-1:0] mem_r [0:(1<<AW)-1];

  // Write port
  always @(posedge ref_clk)
  begin
    if (we)
      mem_r[waddr] <= wdata;
  end

  // Registered read port
  always @(posedge ref_clk)
  begin
    if (srst)
      rdata_r <= {DW{1'b0}};
    else
      rdata_r <= mem_r[raddr];
  end

endmodule // htf_mem

`default_nettype wire

// File: tb/htf_checker.sv
// Port-timing checker for the host telegram framer.
// Bound to htf_framer; sees its ports only, one clock domain.
`timescale 1ns/1ps
`default_nettype none

module htf_checker (
  input wire logic       ref_clk,
  input wire logic       srst,
  input wire logic [7:0] rx_data,
  input wire logic       rx_valid,
  input wire logic [7:0] tx_data,
  input wire logic       tx_valid,
  input wire logic       tx_ready,
  input wire logic       cmd_valid_r,
  input wire logic [7:0] cmd_count_r,
  input wire logic       cmd_bcast_r,
  input wire logic       rsp_req,
  input wire logic       busy_r
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (srst);

  // Delivery strobe lasts one cycle only
  cmd_pulse_a: assert property (cmd_valid_r |=> !cmd_valid_r)
    else $error("cmd_valid_r held longer than one cycle");
  // A delivery follows the end byte by one edge
  after_end_a: assert property (cmd_valid_r |->
    $past(rx_valid) && $past(rx_data) == 8'h03)
    else $error("delivery without end byte just before");
  // Payload never over 128 bytes
  count_max_a: assert property (cmd_valid_r |-> cmd_count_r <= 8'h80)
    else $error("cmd_count_r above 128");
  // A stalled head byte keeps its value
  tx_hold_a: assert property (tx_valid && !tx_ready |=>
    tx_valid && $stable(tx_data))
    else $error("tx byte changed or dropped while stalled");
  // Framer waits for the core after a delivery
  hold_busy_a: assert property (cmd_valid_r |=> busy_r)
    else $error("busy_r not raised after delivery");
  // Answer starts within two edges of the request
  reply_start_a: assert property (busy_r && rsp_req && !cmd_bcast_r
    |-> ##[1:2] tx_valid)
    else $error("response did not start");
  // Broadcast answer request only returns to hunting
  bcast_quiet_a: assert property (busy_r && rsp_req && cmd_bcast_r
    |-> ##[1:3] !busy_r && !tx_valid)
    else $error("broadcast was answered or hold kept");
  // A request outside the hold state is ignored
  stray_rsp_a: assert property (!busy_r && rsp_req && !tx_valid &&
    !rx_valid && !$past(rx_valid) |=> !tx_valid)
    else $error("stray answer request sent bytes");
endmodule // htf_checker

bind htf_framer htf_checker htf_checker_i (
  .ref_clk     (ref_clk),
  .srst        (srst),
  .rx_data     (rx_data),
  .rx_valid    (rx_valid),
  .tx_data     (tx_data),
  .tx_valid    (tx_valid),
  .tx_ready    (tx_ready),
  .cmd_valid_r (cmd_valid_r),
  .cmd_count_r (cmd_count_r),
  .cmd_bcast_r (cmd_bcast_r),
  .rsp_req     (rsp_req),
  .busy_r      (busy_r)
);
`default_nettype wire

// File: tb/htf_host_model.sv
// Host computer model: sends telegrams, collects reply bytes.
// Assumes the framer's byte strobe and tx valid/ready ports.
`timescale 1ns/1ps
`default_nettype none
`include "htf_map.vh"

module htf_host_model (
  input  wire logic       ref_clk,
  output logic      [7:0] rx_data,
  output logic            rx_valid,
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_valid,
  output logic            tx_ready,
  input  wire logic [1:0] stall
);
  logic [7:0] got[$];

  // Idle line at time zero
  initial
  begin
    rx_data = 8'h00;
    rx_valid = 1'b0;
    tx_ready = 1'b0;
  end

  // build a telegram; bad flips bit 0 of the sum
  task automatic mk(input logic [7:0] a, c, r, s, input logic [7:0] d[$],
                    input logic bad, input logic [7:0] e,
                    output logic [7:0] f[$]);
    logic [15:0] sum;
    f = {a, 8'(d.size() + 3), c, r, s};
    f = {f, d};
    sum = 16'h0000;
    foreach (f[i])
      sum += {8'h00, f[i]};
    sum = ~sum ^ {15'h0000, bad};
    f = {`HTF_STX, f, sum[15:8], sum[7:0], e};
  endtask

  // back-to-back bytes; data line inverted once released
  task automatic send(input logic [7:0] f[$]);
    foreach (f[i])
    begin
      @(posedge ref_clk);
      rx_data <= f[i];
      rx_valid <= 1'b1;
    end
    @(posedge ref_clk);
    rx_data <= ~rx_data;
    rx_valid <= 1'b0;
  endtask

  // Stall 0 takes at once, 1 every other cycle, 2 refuses all
  always @(posedge ref_clk)
  begin
    if (tx_valid && tx_ready)
      got.push_back(tx_data);
    tx_ready <= (stall == 2'd0) ? 1'b1 : (stall == 2'd1) ? !tx_ready : 1'b0;
  end
endmodule // htf_host_model
`default_nettype wire

// File: tb/tb_htf_framer.sv
// Testbench of the host telegram framer, one task per scenario.
// Assumes htf_framer, htf_host_model and the bound checker.
`timescale 1ns/1ps
`default_nettype none
`include "htf_map.vh"

module tb_htf_framer;
  logic       ref_clk, srst, rx_valid, tx_valid, tx_ready, pay_we;
  logic       rsp_req, rsp_unknown, cmd_valid_r, cmd_bcast_r, busy_r;
  logic [1:0] stall;
  logic [6:0] station_addr, pay_raddr, pay_waddr;
  logic [7:0] rx_data, tx_data, pay_rdata, pay_wdata, rsp_code, rsp_cond;
  logic [7:0] rsp_count, cmd_code_r, cmd_reserve_r, cmd_cond_r, cmd_count_r;
  logic [7:0] f[$], d[$], x[$];
  int         err_count, total_checks;

  htf_framer htf_framer_i (.ref_clk(ref_clk), .srst(srst),
    .station_addr(station_addr), .rx_data(rx_data), .rx_valid(rx_valid),
    .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .cmd_valid_r(cmd_valid_r), .cmd_code_r(cmd_code_r),
    .cmd_reserve_r(cmd_reserve_r), .cmd_cond_r(cmd_cond_r),
    .cmd_count_r(cmd_count_r), .cmd_bcast_r(cmd_bcast_r),
    .pay_raddr(pay_raddr), .pay_rdata(pay_rdata), .pay_we(pay_we),
    .pay_waddr(pay_waddr), .pay_wdata(pay_wdata), .rsp_req(rsp_req),
    .rsp_code(rsp_code), .rsp_cond(rsp_cond), .rsp_count(rsp_count),
    .rsp_unknown(rsp_unknown), .busy_r(busy_r));
  htf_host_model htf_host_model_i (.ref_clk(ref_clk), .rx_data(rx_data),
    .rx_valid(rx_valid), .tx_data(tx_data), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .stall(stall));

  // 25 MHz clock
  initial
  begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  task automatic chk(input string n, input logic [15:0] e, s);
    total_checks++;
    if (e !== s)
    begin
      err_count++;
      $display("FAIL %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Looks for the delivery strobe in a short window
  task automatic wait_cmd(input logic want);
    logic seen;
    seen = 1'b0;
    // Look first: the strobe stands in the cycle after the end byte is taken
    repeat (4)
    begin
      #1;
      if (cmd_valid_r === 1'b1)
        seen = 1'b1;
      @(posedge ref_clk);
    end
    chk("cmd_valid_r", {15'h0000, want}, {15'h0000, seen});
  endtask

  task automatic respond(input logic [7:0] c, s, n, input logic u);
    @(posedge ref_clk);
    rsp_req <= 1'b1;
    rsp_code <= c;
    rsp_cond <= s;
    rsp_count <= n;
    rsp_unknown <= u;
    @(posedge ref_clk);
    rsp_req <= 1'b0;
  endtask

  // Bounded wait for the whole reply, then a quiet tail for extras
  task automatic get_rsp(input logic [7:0] e[$]);
    int i;
    i = 0;
    while (htf_host_model_i.got.size() < e.size() && i < 400)
    begin
      @(posedge ref_clk);
      i++;
    end
    repeat (12) @(posedge ref_clk);
    chk("reply length", 16'(e.size()), 16'(htf_host_model_i.got.size()));
    if (i == 400)
      stop_test();
    foreach (e[k])
      chk("reply byte", {8'h00, e[k]}, {8'h00, htf_host_model_i.got[k]});
    htf_host_model_i.got.delete();
  endtask

  task automatic t_normal;
    d = {8'h11, 8'h22};
    htf_host_model_i.mk(8'h05, 8'h21, 8'h3b, 8'h5a, d, 1'b0, `HTF_ETX, f);
    htf_host_model_i.send(f);
    wait_cmd(1'b1);
    chk("cmd_code_r", 16'h0021, {8'h00, cmd_code_r});
    chk("cmd_reserve_r", 16'h003b, {8'h00, cmd_reserve_r});
    chk("cmd_cond_r", 16'h005a, {8'h00, cmd_cond_r});
    chk("cmd_count_r", 16'h0002, {8'h00, cmd_count_r});
    pay_raddr <= 7'h01;
    pay_we <= 1'b1;
    pay_wdata <= 8'hc3;
    @(posedge ref_clk);
    pay_waddr <= 7'h01;
    pay_wdata <= 8'h3c;
    @(posedge ref_clk);
    pay_we <= 1'b0;
    stall <= 2'd2;
    #1;
    chk("pay_rdata", 16'h0022, {8'h00, pay_rdata});
    respond(8'h21, 8'h0f, 8'h02, 1'b0);
    repeat (20) @(posedge ref_clk);
    stall <= 2'd1;
    d = {8'hc3, 8'h3c};
    htf_host_model_i.mk(8'h05, 8'ha1, 8'h00, 8'h0f, d, 1'b0, `HTF_ETX, x);
    get_rsp(x);
    stall <= 2'd0;
  endtask

  task automatic t_bcast;
    d.delete();
    htf_host_model_i.mk(8'h7e, 8'h10, 8'h00, 8'h00, d, 1'b0, `HTF_ETX, f);
    htf_host_model_i.send(f);
    wait_cmd(1'b1);
    chk("cmd_bcast_r", 16'h0001, {15'h0000, cmd_bcast_r});
    respond(8'h10, 8'h00, 8'h00, 1'b0);
    get_rsp(d);
  endtask

  // Error acks: bad sum, then unknown command with own condition byte
  task automatic t_errors;
    d.delete();
    htf_host_model_i.mk(8'h05, 8'h21, 8'h00, 8'h00, d, 1'b1, `HTF_ETX, f);
    htf_host_model_i.send(f);
    wait_cmd(1'b0);
    d = {8'h00, 8'h01};
    htf_host_model_i.mk(8'h05, 8'hff, 8'hff, 8'h00, d, 1'b0, `HTF_ETX, x);
    get_rsp(x);
    d.delete();
    htf_host_model_i.mk(8'h05, 8'h77, 8'h00, 8'h00, d, 1'b0, `HTF_ETX, f);
    htf_host_model_i.send(f);
    wait_cmd(1'b1);
    respond(8'h77, 8'h44, 8'h00, 1'b1);
    d = {8'h00, 8'h02};
    htf_host_model_i.mk(8'h05, 8'hff, 8'hff, 8'h44, d, 1'b0, `HTF_ETX, x);
    get_rsp(x);
  endtask

  // Dropped frames: address too high, foreign address, wrong end byte
  task automatic t_drop;
    logic [7:0] ad[3] = '{8'h7f, 8'h06, 8'h05};
    logic [7:0] en[3] = '{`HTF_ETX, `HTF_ETX, 8'h00};
    for (int i = 0; i < 3; i++)
    begin
      d.delete();
      htf_host_model_i.mk(ad[i], 8'h21, 8'h00, 8'h00, d, 1'b0, en[i], f);
      htf_host_model_i.send(f);
      wait_cmd(1'b0);
      respond(8'h21, 8'h00, 8'h00, 1'b0);
      get_rsp(d);
    end
    // Count of 132 is refused; filler bytes hold no start byte
    d.delete();
    repeat (129) d.push_back(8'h55);
    htf_host_model_i.mk(8'h05, 8'h21, 8'h00, 8'h00, d, 1'b0, `HTF_ETX, f);
    htf_host_model_i.send(f);
    wait_cmd(1'b0);
    d.delete();
    get_rsp(d);
  endtask

  // Longest payload accepted, answer count clipped to 128
  task automatic t_long;
    d.delete();
    for (int i = 0; i < 128; i++)
      d.push_back(8'(i));
    htf_host_model_i.mk(8'h05, 8'h30, 8'h00, 8'h00, d, 1'b0, `HTF_ETX, f);
    htf_host_model_i.send(f);
    wait_cmd(1'b1);
    chk("cmd_count_r", 16'h0080, {8'h00, cmd_count_r});
    respond(8'h30, 8'h00, 8'h90, 1'b0);
    htf_host_model_i.mk(8'h05, 8'hb0, 8'h00, 8'h00, d, 1'b0, `HTF_ETX, x);
    get_rsp(x);
  endtask

  // Reset, then the scenarios in turn
  initial
  begin
    err_count = 0;
    total_checks = 0;
    srst = 1'b1;
    station_addr = 7'h05;
    {pay_we, rsp_req, rsp_unknown, stall} = 5'h00;
    {pay_raddr, pay_waddr, pay_wdata} = 22'h000000;
    {rsp_code, rsp_cond, rsp_count} = 24'h000000;
    repeat (12) @(posedge ref_clk);
    srst <= 1'b0;
    #1;
    chk("tx_valid", 16'h0000, {15'h0000, tx_valid});
    chk("busy_r", 16'h0000, {15'h0000, busy_r});
    chk("cmd_count_r", 16'h0000, {8'h00, cmd_count_r});
    chk("pay_rdata", 16'h0000, {8'h00, pay_rdata});
    t_normal();
    t_bcast();
    t_errors();
    t_long();
    t_drop();
    stop_test();
  end
endmodule // tb_htf_framer
`default_nettype wire
